// [rcs_clk_model.sv]
`timescale 1ns/10ps
module rcs_clk_model (
  input  wire logic        clock_i,
  input  wire logic        sleep_on_i,
  input  wire logic [15:0] ref_khz_i,
  output logic             ref_tick_o = 1'b0,
  output logic             sleep_clk_o = 1'b0
);
  localparam int SLP_PER = 400;
  localparam int TICK_TH = 32768 * SLP_PER;
  int phase = 0;
  int cnt = 0;
  // Scaled time, ref ticks per sleep period stay ref_hz / 32768 for ref_hz up to 32768 * 400; at most one tick per clock
  always @(posedge clock_i) begin
    phase = phase + ref_khz_i * 1000;
    ref_tick_o <= (phase >= TICK_TH);
    if (phase >= TICK_TH) begin
      phase = phase - TICK_TH;
    end
    cnt = (cnt + 1) % SLP_PER;
    sleep_clk_o <= sleep_on_i && (cnt < SLP_PER / 2);
  end
endmodule

// [rcs_freq_rom.sv]
`timescale 1ns/10ps
module rcs_freq_rom
  import rcs_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic [4:0]  addr_i,
  output logic      [16:0] count_o,
  output logic      [15:0] khz_o
);
  logic [32:0] word;

  // Expected reference ticks over 64 sleep periods, and kHz
  always_comb begin
    case (addr_i)
      5'h00:   word = {17'h05B8E, 16'h2EE0};
      5'h01:   word = {17'h0632F, 16'h32C8};
      5'h02:   word = {17'h06DDD, 16'h3840};
      5'h03:   word = {17'h07530, 16'h3C00};
      5'h04:   word = {17'h07B99, 16'h3F48};
      5'h05:   word = {17'h0802D, 16'h41A0};
      5'h06:   word = {17'h08954, 16'h4650};
      5'h07:   word = {17'h0927C, 16'h4B00};
      5'h08:   word = {17'h09451, 16'h4BF0};
      5'h09:   word = {17'h09626, 16'h4CE0};
      5'h0A:   word = {17'h09710, 16'h4D58};
      5'h0B:   word = {17'h09897, 16'h4E20};
      5'h0C:   word = {17'h0B71B, 16'h5DC0};
      5'h0D:   word = {17'h0C65D, 16'h6590};
      5'h0E:   word = {17'h10059, 16'h8340};
      5'h0F:   word = {17'h11D57, 16'h9218};
      5'h10:   word = {17'h124F8, 16'h9600};
      default: word = 33'h0;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= 17'h0;
      khz_o   <= 16'h0;
    end else if (ce_i) begin
      count_o <= word[32:16];
      khz_o   <= word[15:0];
    end
  end
endmodule

// [rcs_pkg.sv]
// Functional notes
// - A floating or high frequency strap selects a 20 MHz reference; the pin is pulled up.
// - A low frequency strap selects a 26 MHz reference.
// - With a stable sleep clock during power-on, the reference is measured and programmed.
// - Auto-detection recognises exactly the seventeen standard handset frequencies.
// - Without a sleep clock the order is autobaud (UART only), then memory, then strap.
// - Parameters loaded from external memory at power-on may set frequency and trim.
// - Trim is digital, through the synthesizer, to 2 ppm, with no change to input loading.
// - Trim comes from a host command or from memory at power-on, as the host chooses.
// - The trim range is plus or minus 50 ppm for crystal and external reference.
// - Any reference from 12 to 52 MHz is programmable in 2 ppm steps of about 80 Hz.
// - With an external TCXO a clock-request output shows when the reference is needed.
// - Sniff intervals are timed from the external or internal sleep clock.
// - Optionally the sleep clock is derived from the main reference clock.
// - Serial bit timing is usable only once the reference frequency is resolved.
// - Clock request is an alternate function of a general pin, polarity set by a strap.
// - The autobaud result returns the detected baud rate selection.
package rcs_pkg;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FREQ   = 8'h04;
  localparam logic [7:0] OFF_TRIM   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_SNIFF  = 8'h10;

  localparam int CTRL_TCXO_BIT   = 0;
  localparam int CTRL_ALT_BIT    = 1;
  localparam int CTRL_SRC_LSB    = 2;
  localparam int CTRL_GPIO_OE    = 4;
  localparam int ST_RESOLVED_BIT = 0;
  localparam int ST_SLEEP_BIT    = 1;
  localparam int ST_SRC_LSB      = 2;
  localparam int ST_BAUD_LSB     = 5;

  localparam logic [4:0]  CTRL_RESET  = 5'h00;
  localparam logic [15:0] SNIFF_RESET = 16'h0800;

  localparam logic [1:0] SLP_EXTERNAL = 2'h0;
  localparam logic [1:0] SLP_INTERNAL = 2'h1;
  localparam logic [1:0] SLP_DERIVED  = 2'h2;

  localparam logic [2:0] SRC_NONE  = 3'h0;
  localparam logic [2:0] SRC_AUTO  = 3'h1;
  localparam logic [2:0] SRC_BAUD  = 3'h2;
  localparam logic [2:0] SRC_NVM   = 3'h3;
  localparam logic [2:0] SRC_STRAP = 3'h4;
  localparam logic [2:0] SRC_HOST  = 3'h5;

  localparam logic [15:0] KHZ_STRAP_HIGH = 16'h4E20;
  localparam logic [15:0] KHZ_STRAP_LOW  = 16'h6590;
  localparam logic [15:0] KHZ_MIN        = 16'h2EE0;
  localparam logic [15:0] KHZ_MAX        = 16'hCB20;
  localparam logic [25:0] HZ_PER_KHZ     = 26'h00003E8;
  localparam logic [25:0] SLEEP_HZ       = 26'h0008000;

  localparam int TRIM_STEP_PPM  = 2;
  localparam int TRIM_RANGE_PPM = 50;
  localparam logic signed [6:0] TRIM_MAX = 7'(TRIM_RANGE_PPM / TRIM_STEP_PPM);

  localparam int          ROM_DEPTH    = 17;
  localparam logic [4:0]  ROM_LAST     = 5'h10;
  localparam logic [5:0]  MEAS_LAST    = 6'h3F;
  localparam logic [2:0]  DET_EDGES    = 3'h4;
  localparam int          TOL_SHIFT    = 9;

  localparam int CLK_PERIOD_NS   = 5;
  localparam int DET_TIMEOUT_NS  = 100000;
  localparam int DET_TIMEOUT_CYC = DET_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int BAUD_TIMEOUT_NS  = 200000;
  localparam int BAUD_TIMEOUT_CYC = BAUD_TIMEOUT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic             valid;
    logic             has_freq;
    logic [15:0]      freq_khz;
    logic             has_trim;
    logic signed [6:0] trim;
  } rcs_nvm_t;

  typedef struct packed {
    logic [15:0]       freq_khz;
    logic signed [6:0] trim_steps;
  } rcs_ref_cfg_t;

  typedef enum logic [6:0] {
    ST_STRAP   = 7'h01,
    ST_DETECT  = 7'h02,
    ST_MEASURE = 7'h04,
    ST_LOOKUP  = 7'h08,
    ST_BAUD    = 7'h10,
    ST_NVM     = 7'h20,
    ST_DONE    = 7'h40
  } rcs_state_t;
endpackage

// [rcs_props.sv]
`timescale 1ns/10ps
module rcs_props
  import rcs_pkg::*;
(
  input wire logic         clock_i,
  input wire logic         reset_n_i,
  input wire logic         reg_we_i,
  input wire logic         reg_re_i,
  input wire logic [31:0]  reg_rdata_o,
  input wire rcs_ref_cfg_t ref_cfg_o,
  input wire logic [4:0]   baud_sel_o,
  input wire logic         timing_ready_o,
  input wire logic         sleep_tick_o,
  input wire logic         sniff_wake_o,
  input wire logic         gpio_oe_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  read_idle_a: assert property (!reg_re_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside slot");
  freq_range_a: assert property (
    timing_ready_o |-> ref_cfg_o.freq_khz inside {[KHZ_MIN:KHZ_MAX]})
    else $error("frequency out of range");
  trim_range_a: assert property (
    ref_cfg_o.trim_steps <= TRIM_MAX && ref_cfg_o.trim_steps >= -TRIM_MAX)
    else $error("trim out of range");
  ready_hold_a: assert property (timing_ready_o |=> timing_ready_o)
    else $error("ready dropped");
  freq_hold_a: assert property (
    $past(timing_ready_o) && !$past(reg_we_i) && !$past(reg_we_i, 2)
      |-> $stable(ref_cfg_o.freq_khz))
    else $error("frequency changed without write");
  baud_hold_a: assert property ($past(timing_ready_o) |-> $stable(baud_sel_o))
    else $error("baud changed after resolution");
  tick_pulse_a: assert property (sleep_tick_o |=> !sleep_tick_o)
    else $error("sleep tick too long");
  wake_pulse_a: assert property (sniff_wake_o |=> !sniff_wake_o)
    else $error("wake pulse too long");
  oe_cause_a: assert property (
    $changed(gpio_oe_o) |-> $past(reg_we_i) || $past(reg_we_i, 2) || $past(reg_we_i, 3))
    else $error("pin enable changed without write");
endmodule

// [rcs_top.sv]
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
module rcs_top
  import rcs_pkg::*;
#(
  parameter int DET_TIMEOUT  = DET_TIMEOUT_CYC,
  parameter int BAUD_TIMEOUT = BAUD_TIMEOUT_CYC
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic         ce_i,
  input  wire logic         ref_tick_i,
  input  wire logic         sleep_clock_input_i,
  input  wire logic         int_osc_tick_i,
  input  wire logic         ref_select_strap_i,
  input  wire logic         request_polarity_strap_i,
  input  wire logic         autobaud_en_i,
  input  wire logic         uart_host_i,
  input  wire logic         autobaud_lock_i,
  input  wire logic [15:0]  autobaud_khz_i,
  input  wire logic [4:0]   autobaud_baud_i,
  input  wire rcs_nvm_t     nvm_i,
  input  wire logic         nvm_done_i,
  input  wire logic         sniff_active_i,
  input  wire logic         gpio_data_i,
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic [31:0]  reg_wdata_i,
  input  wire logic         reg_we_i,
  input  wire logic         reg_re_i,
  output logic [31:0]       reg_rdata_o,
  output rcs_ref_cfg_t      ref_cfg_o,
  output logic [4:0]        baud_sel_o,
  output logic              timing_ready_o,
  output logic              sleep_tick_o,
  output logic              sniff_wake_o,
  output logic              gpio_o,
  output logic              gpio_oe_o
);
  rcs_state_t        state_reg, state_next;
  logic [4:0]        ctrl_reg, ctrl_next;
  logic [15:0]       khz_reg, khz_next;
  logic signed [6:0] trim_reg, trim_next;
  logic [15:0]       sniff_int_reg, sniff_int_next;
  logic [2:0]        src_reg, src_next;
  logic              sel_strap_reg, sel_strap_next;
  logic              pol_reg, pol_next;
  logic              slp_seen_reg, slp_seen_next;
  logic              nvm_trim_done_reg, nvm_trim_done_next;
  logic [4:0]        baud_reg, baud_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [31:0]       wait_reg, wait_next;
  logic [2:0]        edges_reg, edges_next;
  logic [5:0]        per_reg, per_next;
  logic [16:0]       meas_reg, meas_next;
  logic [4:0]        idx_reg, idx_next;
  logic              cmp_ok_reg, cmp_ok_next;
  logic              slp_prev_reg;
  logic [16:0]       rom_count;
  logic [15:0]       rom_khz;
  logic [16:0]       diff;
  logic              slp_edge;

  function automatic logic signed [6:0] clamp_trim(input logic signed [6:0] v);
    return (v > TRIM_MAX) ? TRIM_MAX : ((v < -TRIM_MAX) ? -TRIM_MAX : v);
  endfunction

  function automatic logic [15:0] clamp_khz(input logic [15:0] v);
    return (v < KHZ_MIN) ? KHZ_MIN : ((v > KHZ_MAX) ? KHZ_MAX : v);
  endfunction

  rcs_freq_rom u_rom (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .addr_i    (idx_reg),
    .count_o   (rom_count),
    .khz_o     (rom_khz)
  );

  assign slp_edge = sleep_clock_input_i & ~slp_prev_reg;
  assign diff     = (meas_reg > rom_count) ? meas_reg - rom_count : rom_count - meas_reg;

  // Resolution sequence and register file
  always_comb begin
    state_next         = state_reg;
    ctrl_next          = ctrl_reg;
    khz_next           = khz_reg;
    trim_next          = trim_reg;
    sniff_int_next     = sniff_int_reg;
    src_next           = src_reg;
    sel_strap_next     = sel_strap_reg;
    pol_next           = pol_reg;
    slp_seen_next      = slp_seen_reg;
    nvm_trim_done_next = nvm_trim_done_reg;
    baud_next          = baud_reg;
    wait_next          = wait_reg + 32'h1;
    edges_next         = edges_reg;
    per_next           = per_reg;
    meas_next          = meas_reg;
    idx_next           = idx_reg;
    cmp_ok_next        = 1'b0;
    rdata_next         = 32'h0;
    case (state_reg)
      ST_STRAP: begin
        sel_strap_next = ref_select_strap_i;
        pol_next       = request_polarity_strap_i;
        wait_next      = 32'h0;
        edges_next     = 3'h0;
        state_next     = ST_DETECT;
      end
      ST_DETECT: begin
        edges_next = edges_reg + {2'h0, slp_edge};
        if (slp_edge && edges_reg == DET_EDGES - 3'h1) begin
          slp_seen_next = 1'b1;
          per_next      = 6'h0;
          meas_next     = 17'h0;
          state_next    = ST_MEASURE;
        end else if (wait_reg >= 32'(DET_TIMEOUT)) begin
          wait_next  = 32'h0;
          state_next = ST_BAUD;
        end
      end
      ST_MEASURE: begin
        if (ref_tick_i && meas_reg != 17'h1FFFF) begin
          meas_next = meas_reg + 17'h1;
        end
        if (slp_edge) begin
          per_next = per_reg + 6'h1;
          if (per_reg == MEAS_LAST) begin
            idx_next   = 5'h0;
            state_next = ST_LOOKUP;
          end
        end
      end
      ST_LOOKUP: begin
        // ROM data lag the index by one cycle
        cmp_ok_next = 1'b1;
        if (idx_reg != ROM_LAST) begin
          idx_next = idx_reg + 5'h1;
        end
        if (cmp_ok_reg && diff <= (rom_count >> TOL_SHIFT)) begin
          khz_next   = rom_khz;
          src_next   = SRC_AUTO;
          state_next = ST_DONE;
        end else if (cmp_ok_reg && idx_reg == ROM_LAST) begin
          idx_next    = 5'h1F;
        end else if (idx_reg == 5'h1F) begin
          wait_next  = 32'h0;
          state_next = ST_BAUD;
        end
      end
      ST_BAUD: begin
        if (!(autobaud_en_i && uart_host_i) || wait_reg >= 32'(BAUD_TIMEOUT)) begin
          state_next = ST_NVM;
        end else if (autobaud_lock_i) begin
          khz_next   = clamp_khz(autobaud_khz_i);
          baud_next  = autobaud_baud_i;
          src_next   = SRC_BAUD;
          state_next = ST_DONE;
        end
      end
      ST_NVM: begin
        if (nvm_done_i) begin
          state_next = ST_DONE;
          if (nvm_i.valid && nvm_i.has_freq) begin
            khz_next = clamp_khz(nvm_i.freq_khz);
            src_next = SRC_NVM;
          end else begin
            khz_next = sel_strap_reg ? KHZ_STRAP_HIGH : KHZ_STRAP_LOW;
            src_next = SRC_STRAP;
          end
        end
      end
      ST_DONE: wait_next = wait_reg;
      default: state_next = ST_STRAP;
    endcase
    // Memory trim applies once, clamped to the trim range
    if (nvm_done_i && !nvm_trim_done_reg) begin
      nvm_trim_done_next = 1'b1;
      if (nvm_i.valid && nvm_i.has_trim) begin
        trim_next = clamp_trim(nvm_i.trim);
      end
    end
    if (reg_we_i) begin
      case (reg_addr_i)
        OFF_CTRL: ctrl_next = reg_wdata_i[4:0];
        OFF_FREQ: begin
          khz_next   = clamp_khz(reg_wdata_i[15:0]);
          src_next   = SRC_HOST;
          state_next = ST_DONE;
        end
        OFF_TRIM:  trim_next = clamp_trim(reg_wdata_i[6:0]);
        OFF_SNIFF: sniff_int_next = reg_wdata_i[15:0];
        default:   ctrl_next = ctrl_reg;
      endcase
    end
    if (reg_re_i) begin
      case (reg_addr_i)
        OFF_CTRL:   rdata_next = {27'h0, ctrl_reg};
        OFF_FREQ:   rdata_next = {16'h0, khz_reg};
        OFF_TRIM:   rdata_next = {{25{trim_reg[6]}}, trim_reg};
        OFF_STATUS: rdata_next = {22'h0, baud_reg, src_reg, slp_seen_reg,
                                  state_reg == ST_DONE};
        OFF_SNIFF:  rdata_next = {16'h0, sniff_int_reg};
        default:    rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg         <= ST_STRAP;
      ctrl_reg          <= CTRL_RESET;
      khz_reg           <= KHZ_STRAP_HIGH;
      trim_reg          <= 7'sh00;
      sniff_int_reg     <= SNIFF_RESET;
      src_reg           <= SRC_NONE;
      sel_strap_reg     <= 1'b1;
      pol_reg           <= 1'b1;
      slp_seen_reg      <= 1'b0;
      nvm_trim_done_reg <= 1'b0;
      baud_reg          <= 5'h0;
      rdata_reg         <= 32'h0;
      wait_reg          <= 32'h0;
      edges_reg         <= 3'h0;
      per_reg           <= 6'h0;
      meas_reg          <= 17'h0;
      idx_reg           <= 5'h0;
      cmp_ok_reg        <= 1'b0;
      slp_prev_reg      <= 1'b0;
    end else if (ce_i) begin
      state_reg         <= state_next;
      ctrl_reg          <= ctrl_next;
      khz_reg           <= khz_next;
      trim_reg          <= trim_next;
      sniff_int_reg     <= sniff_int_next;
      src_reg           <= src_next;
      sel_strap_reg     <= sel_strap_next;
      pol_reg           <= pol_next;
      slp_seen_reg      <= slp_seen_next;
      nvm_trim_done_reg <= nvm_trim_done_next;
      baud_reg          <= baud_next;
      rdata_reg         <= rdata_next;
      wait_reg          <= wait_next;
      edges_reg         <= edges_next;
      per_reg           <= per_next;
      meas_reg          <= meas_next;
      idx_reg           <= idx_next;
      cmp_ok_reg        <= cmp_ok_next;
      slp_prev_reg      <= sleep_clock_input_i;
    end
  end

  // Sleep clock, sniff timer and clock request
  logic [25:0] acc_reg, acc_next;
  logic [25:0] ref_hz;
  logic [15:0] sniff_cnt_reg, sniff_cnt_next;
  logic        stick_reg, stick_next;
  logic        wake_reg, wake_next;
  logic        gpio_reg, gpio_next;
  logic        oe_reg, oe_next;
  logic        ready_reg, ready_next;
  logic        need;
  logic [1:0]  slp_src;

  assign ref_hz  = 26'({10'h0, khz_reg} * HZ_PER_KHZ);
  assign slp_src = ctrl_reg[CTRL_SRC_LSB +: 2];

  always_comb begin
    acc_next       = acc_reg;
    sniff_cnt_next = sniff_cnt_reg;
    wake_next      = 1'b0;
    case (slp_src)
      SLP_EXTERNAL: stick_next = slp_edge;
      SLP_INTERNAL: stick_next = int_osc_tick_i;
      SLP_DERIVED: begin
        stick_next = 1'b0;
        if (ref_tick_i) begin
          if (acc_reg + SLEEP_HZ >= ref_hz) begin
            acc_next   = acc_reg + SLEEP_HZ - ref_hz;
            stick_next = 1'b1;
          end else begin
            acc_next = acc_reg + SLEEP_HZ;
          end
        end
      end
      default: stick_next = 1'b0;
    endcase
    if (!sniff_active_i) begin
      sniff_cnt_next = 16'h0;
    end else if (stick_next) begin
      if (sniff_cnt_reg + 16'h1 >= sniff_int_reg) begin
        sniff_cnt_next = 16'h0;
        wake_next      = 1'b1;
      end else begin
        sniff_cnt_next = sniff_cnt_reg + 16'h1;
      end
    end
    need       = ctrl_reg[CTRL_TCXO_BIT] & (~sniff_active_i | wake_next);
    ready_next = (state_next == ST_DONE);
    oe_next    = ctrl_reg[CTRL_GPIO_OE] | ctrl_reg[CTRL_ALT_BIT];
    if (ctrl_reg[CTRL_ALT_BIT]) begin
      gpio_next = pol_reg ? need : ~need;
    end else begin
      gpio_next = gpio_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_reg       <= 26'h0;
      sniff_cnt_reg <= 16'h0;
      stick_reg     <= 1'b0;
      wake_reg      <= 1'b0;
      gpio_reg      <= 1'b0;
      oe_reg        <= 1'b0;
      ready_reg     <= 1'b0;
    end else if (ce_i) begin
      acc_reg       <= acc_next;
      sniff_cnt_reg <= sniff_cnt_next;
      stick_reg     <= stick_next;
      wake_reg      <= wake_next;
      gpio_reg      <= gpio_next;
      oe_reg        <= oe_next;
      ready_reg     <= ready_next;
    end
  end

  assign reg_rdata_o          = rdata_reg;
  assign ref_cfg_o.freq_khz   = khz_reg;
  assign ref_cfg_o.trim_steps = trim_reg;
  assign baud_sel_o           = baud_reg;
  assign timing_ready_o       = ready_reg;
  assign sleep_tick_o         = stick_reg;
  assign sniff_wake_o         = wake_reg;
  assign gpio_o               = gpio_reg;
  assign gpio_oe_o            = oe_reg;
endmodule

// [rcs_top_bench.sv]
`timescale 1ns/10ps
module rcs_top_bench
  import rcs_pkg::*;
;
  typedef struct {int strap, ab, uart, nvm, slp, rk;} rcs_case_t;
  logic         clock_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, ref_tick_i, sleep_clock_input_i;
  logic         int_osc_tick_i = 1'b0, ref_select_strap_i = 1'b1, request_polarity_strap_i = 1'b1;
  logic         autobaud_en_i = 1'b0, uart_host_i = 1'b0, autobaud_lock_i = 1'b0;
  logic         nvm_done_i = 1'b1, sniff_active_i = 1'b0, gpio_data_i = 1'b0;
  logic         reg_we_i = 1'b0, reg_re_i = 1'b0, sleep_on = 1'b0, p;
  logic [15:0]  autobaud_khz_i = 16'h4B00, ref_khz = 16'h32C8;
  logic [4:0]   autobaud_baud_i = 5'h00, baud_sel_o;
  rcs_nvm_t     nvm_i = '0;
  logic [7:0]   reg_addr_i = 8'h00;
  logic [31:0]  reg_wdata_i = 32'h0, reg_rdata_o, d;
  rcs_ref_cfg_t ref_cfg_o;
  logic         timing_ready_o, sleep_tick_o, sniff_wake_o, gpio_o, gpio_oe_o;
  logic [16:0]  seed = 17'h131EF;
  int           n_mismatch = 0, check_count = 0, n_tick = 0, n_wake = 0, s, f, tr, a, b;
  int           std_q[$] = '{12000, 13000, 14400, 15360, 16200, 16800, 18000, 19200, 19440,
                             19680, 19800, 20000, 24000, 26000, 33600, 37400, 38400};
  int           fw[3] = '{60000, 5000, 38400}, fe[3] = '{52000, 12000, 38400};
  int           tw[3] = '{40, -40, 3}, te[3] = '{25, -25, 3};
  rcs_case_t    cases[6] = '{'{1, 0, 0, 0, 1, 13000}, '{0, 0, 0, 0, 1, 12500},
                             '{1, 1, 1, 33600, 0, 13000}, '{0, 1, 0, 37400, 0, 13000},
                             '{1, 0, 0, 0, 0, 13000}, '{0, 0, 0, 0, 0, 13000}};
  rcs_case_t    c;

  rcs_top #(.DET_TIMEOUT(2500), .BAUD_TIMEOUT(50)) dut_u (.*);
  rcs_clk_model ref_u (.clock_i(clock_i), .sleep_on_i(sleep_on), .ref_khz_i(ref_khz),
                       .ref_tick_o(ref_tick_i), .sleep_clk_o(sleep_clock_input_i));

  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    n_tick <= n_tick + (sleep_tick_o === 1'b1);
    n_wake <= n_wake + (sniff_wake_o === 1'b1);
  end

  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  function automatic int exp_src(rcs_case_t k);
    foreach (std_q[i]) begin
      if (k.slp != 0 && std_q[i] == k.rk)
        return int'(SRC_AUTO);
    end
    if (k.ab != 0 && k.uart != 0)
      return int'(SRC_BAUD);
    if (k.nvm != 0)
      return int'(SRC_NVM);
    return int'(SRC_STRAP);
  endfunction
  task automatic results();
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_wdata_i <= dt;
    reg_we_i <= 1'b1;
    @(posedge clock_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge clock_i);
    reg_addr_i <= ad;
    reg_re_i <= 1'b1;
    @(posedge clock_i);
    reg_re_i <= 1'b0;
    @(negedge clock_i);
    dt = reg_rdata_o;
  endtask
  task automatic settle();
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic wait_ready();
    int k;
    for (k = 0; k < 40000 && timing_ready_o !== 1'b1; k++) begin
      @(posedge clock_i);
    end
    if (k == 40000) begin
      n_mismatch++;
      $display("BAD %0t no resolution", $time);
      results();
    end
  endtask

  initial begin
    foreach (cases[i]) begin
      c = cases[i];
      seed = lfsr(seed);
      tr = int'(seed[9:5]) - 16;
      p = seed[10];
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      ref_select_strap_i <= c.strap[0];
      autobaud_en_i <= c.ab[0];
      uart_host_i <= c.uart[0];
      autobaud_lock_i <= c.ab[0];
      autobaud_baud_i <= seed[4:0];
      request_polarity_strap_i <= p;
      nvm_i <= '{1'b1, c.nvm != 0, 16'(c.nvm), 1'b1, 7'(tr)};
      sleep_on <= c.slp[0];
      ref_khz <= 16'(c.rk);
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      repeat (2) @(negedge clock_i);
      chk(timing_ready_o, 32'h0);
      wait_ready();
      s = exp_src(c);
      case (s)
        int'(SRC_AUTO): f = c.rk;
        int'(SRC_BAUD): f = 19200;
        int'(SRC_NVM): f = c.nvm;
        default: f = c.strap ? 20000 : 26000;
      endcase
      @(negedge clock_i);
      chk(ref_cfg_o.freq_khz, 32'(f));
      chk(32'(ref_cfg_o.trim_steps), 32'(tr));
      if (s == int'(SRC_BAUD))
        chk(baud_sel_o, seed[4:0]);
      rd(OFF_STATUS, d);
      chk(d & 32'h1F, {27'h0, 3'(s), c.slp[0], 1'b1});
      @(posedge clock_i);
      ref_select_strap_i <= ~c.strap[0];
      repeat (10) @(negedge clock_i);
      chk(ref_cfg_o.freq_khz, 32'(f));
    end
    rd(OFF_CTRL, d);
    chk(d, 32'(CTRL_RESET));
    rd(OFF_SNIFF, d);
    chk(d, 32'(SNIFF_RESET));
    rd(8'h14, d);
    chk(d, 32'h0);
    foreach (fw[i]) begin
      wr(OFF_FREQ, 32'(fw[i]));
      settle();
      chk(ref_cfg_o.freq_khz, 32'(fe[i]));
    end
    rd(OFF_STATUS, d);
    chk(d[4:2], 32'(SRC_HOST));
    foreach (tw[i]) begin
      wr(OFF_TRIM, 32'(tw[i]));
      settle();
      chk(32'(ref_cfg_o.trim_steps), 32'(te[i]));
    end
    wr(OFF_CTRL, 32'h13);
    settle();
    chk({gpio_oe_o, gpio_o}, {1'b1, p});
    @(posedge clock_i);
    sniff_active_i <= 1'b1;
    settle();
    chk({gpio_oe_o, gpio_o}, {1'b1, ~p});
    seed = lfsr(seed);
    @(posedge clock_i);
    gpio_data_i <= seed[0];
    wr(OFF_CTRL, 32'h10);
    settle();
    chk(gpio_o, seed[0]);
    wr(OFF_SNIFF, 32'h4);
    wr(OFF_CTRL, 32'h04);
    a = n_tick;
    b = n_wake;
    repeat (20) begin
      @(posedge clock_i);
      int_osc_tick_i <= 1'b1;
      @(posedge clock_i);
      int_osc_tick_i <= 1'b0;
      repeat (8) @(posedge clock_i);
    end
    @(negedge clock_i);
    chk(n_tick - a, 20);
    chk(n_wake - b, 5);
    wr(OFF_CTRL, 32'h08);
    a = n_tick;
    repeat (4000) @(posedge clock_i);
    @(negedge clock_i);
    chk(n_tick - a, 3);
    results();
  end
endmodule

bind rcs_top rcs_props chk_u (.*);
